// ---- common/core_map_pkg.sv ----
// Constants for the core register file and data-space map
package core_map_pkg;
  localparam int GPR_COUNT = 32;
  localparam int DATA_W = 8;
  localparam int IO_COUNT = 64;
  localparam int SRAM_BYTES = 512;
  localparam int PM_WORDS = 4096;
  localparam int DADDR_W = 16;
  localparam int PC_W = 12;
  localparam logic [15:0] GPR_BASE = 16'h0000;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] SRAM_END = 16'h025F;
  localparam logic [5:0] IO_SPL = 6'h3D;
  localparam logic [5:0] IO_SPH = 6'h3E;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [11:0] PC_RESET = 12'h000;
  // ALU operations
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_AND = 4'h2, ALU_OR = 4'h3,
    ALU_XOR = 4'h4, ALU_MOV = 4'h5, ALU_INC = 4'h6, ALU_DEC = 4'h7,
    ALU_COM = 4'h8, ALU_NEG = 4'h9, ALU_LSR = 4'hA, ALU_SWAP = 4'hB
  } alu_op_e;
  // Stack sequencing states, Gray along push; pop flips two bits from IDLE to POP_LO
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_PUSH_HI = 2'b01, ST_POP_LO = 2'b11, ST_POP_HI = 2'b10
  } stack_state_e;
endpackage

// ---- core/sram_512x8.sv ----
// Internal data SRAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module sram_512x8 #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // Clock
  input wire logic clock,
  // Access port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  // Read-before-write, data held in a register
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ---- core/core_register_file_data_map.sv ----
// Core register file, pointer pairs, data-space map, stack and fetch pipeline
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Thirty-two byte registers, single-cycle access.
// - Two operands read, result written same cycle.
// - Six registers form three 16-bit pointers.
// - Top pointer addresses program-memory constant lookups.
// - ALU does reg-reg, immediate-reg, single-reg ops.
// - Registers occupy lowest 32 data addresses.
// - 64 I/O addresses, direct or above registers.
// - Fetch next word while current one executes.
// - Relative jumps reach whole 4K-word space.
// - Program words are 16-bit or half of 32.
// - Calls and interrupts push return counter.
// - Stack pointer 16 bits, read/write via I/O.
// - 512 bytes SRAM in the data space.
// - Linear maps, no banking or holes.
module core_register_file_data_map #(
  parameter int PC_W = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register operand port from the execution unit
  input wire logic [4:0] rd_sel,
  input wire logic [4:0] rr_sel,
  input wire logic [7:0] imm,
  input wire logic use_imm,
  input wire logic [3:0] alu_op,
  input wire logic alu_we,
  // Data-space access (loads, stores, I/O direct)
  input wire logic [15:0] d_addr,
  input wire logic d_rd,
  input wire logic d_wr,
  input wire logic [7:0] d_wdata,
  input wire logic io_direct,
  input wire logic [1:0] ptr_sel,
  // Program flow
  input wire logic [15:0] pm_rdata,
  input wire logic rel_jump,
  input wire logic [11:0] rel_off,
  input wire logic call_req,
  input wire logic irq_req,
  input wire logic [PC_W-1:0] call_target,
  input wire logic ret_req,
  input wire logic long_insn,
  // External I/O peripheral space
  input wire logic [7:0] io_rdata,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic io_re,
  // Results
  output logic [7:0] alu_result,
  output logic [7:0] d_rdata,
  output logic [15:0] ptr_value,
  output logic [15:0] lpm_addr,
  output logic [PC_W-1:0] pm_addr,
  output logic [15:0] insn_q,
  output logic [15:0] stack_pointer,
  output logic stack_busy
);
  logic [7:0] gpr_q [core_map_pkg::GPR_COUNT];
  logic [15:0] sp_q;
  logic [PC_W-1:0] pc_q;
  logic [15:0] insn_r;
  logic [7:0] alu_r, drd_r;
  logic [15:0] ptr_r, lpm_r;
  logic [5:0] ioa_r;
  logic [7:0] iowd_r;
  logic iowe_r, iore_r;
  core_map_pkg::stack_state_e st_q, st_d;
  logic [7:0] ret_hi_q;
  logic busy_q;

  // ALU function shared by all operand forms
  function automatic logic [7:0] alu_fn(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
    case (op)
      core_map_pkg::ALU_ADD: alu_fn = a + b;
      core_map_pkg::ALU_SUB: alu_fn = a - b;
      core_map_pkg::ALU_AND: alu_fn = a & b;
      core_map_pkg::ALU_OR: alu_fn = a | b;
      core_map_pkg::ALU_XOR: alu_fn = a ^ b;
      core_map_pkg::ALU_MOV: alu_fn = b;
      core_map_pkg::ALU_INC: alu_fn = a + 8'h01;
      core_map_pkg::ALU_DEC: alu_fn = a - 8'h01;
      core_map_pkg::ALU_COM: alu_fn = ~a;
      core_map_pkg::ALU_NEG: alu_fn = 8'h00 - a;
      core_map_pkg::ALU_LSR: alu_fn = {1'b0, a[7:1]};
      core_map_pkg::ALU_SWAP: alu_fn = {a[3:0], a[7:4]};
      default: alu_fn = a;
    endcase
  endfunction

  // Pointer pair read by low register index
  function automatic logic [15:0] pair_fn(input logic [4:0] lo);
    pair_fn = {gpr_q[lo + 5'h01], gpr_q[lo]};
  endfunction

  // Operand selection and ALU result
  wire [7:0] op_a = gpr_q[rd_sel];
  wire [7:0] op_b = use_imm ? imm : gpr_q[rr_sel];
  wire [7:0] alu_val = alu_fn(alu_op, op_a, op_b);

  // Pointer selection, Z also feeds constant lookups
  wire [4:0] ptr_lo = (ptr_sel == 2'd0) ? core_map_pkg::PTR_X_LO :
                      (ptr_sel == 2'd1) ? core_map_pkg::PTR_Y_LO : core_map_pkg::PTR_Z_LO;
  wire [15:0] ptr_val = pair_fn(ptr_lo);
  wire [15:0] z_val = pair_fn(core_map_pkg::PTR_Z_LO);

  // Linear data-space decode: registers, I/O, SRAM
  wire [15:0] io_span = core_map_pkg::IO_BASE + 16'(core_map_pkg::IO_COUNT);
  wire hit_gpr = !io_direct && (d_addr < core_map_pkg::IO_BASE);
  wire hit_io = io_direct || (d_addr >= core_map_pkg::IO_BASE && d_addr < io_span);
  wire hit_sram = !io_direct && d_addr >= core_map_pkg::SRAM_BASE && d_addr <= core_map_pkg::SRAM_END;
  wire [5:0] io_idx = io_direct ? d_addr[5:0] : 6'(d_addr - core_map_pkg::IO_BASE);
  wire [4:0] gpr_idx = d_addr[4:0];
  wire hit_spl = hit_io && io_idx == core_map_pkg::IO_SPL;
  wire hit_sph = hit_io && io_idx == core_map_pkg::IO_SPH;
  wire io_ext = hit_io && !hit_spl && !hit_sph;
  wire [8:0] sram_off = 9'(d_addr - core_map_pkg::SRAM_BASE);

  // Stack sequencing; the core stalls while it runs
  wire push_start = (call_req || irq_req) && st_q == core_map_pkg::ST_IDLE;
  wire pop_start = ret_req && st_q == core_map_pkg::ST_IDLE;
  wire [PC_W-1:0] ret_pc = pc_q;
  wire [15:0] ret_ext = 16'(ret_pc);
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      core_map_pkg::ST_IDLE: begin
        if (push_start) begin
          st_d = core_map_pkg::ST_PUSH_HI;
        end else if (pop_start) begin
          st_d = core_map_pkg::ST_POP_LO;
        end
      end
      core_map_pkg::ST_PUSH_HI: st_d = core_map_pkg::ST_IDLE;
      core_map_pkg::ST_POP_LO: st_d = core_map_pkg::ST_POP_HI;
      core_map_pkg::ST_POP_HI: st_d = core_map_pkg::ST_IDLE;
    endcase
  end

  // SRAM port sharing between stack and data accesses
  wire stk_wr = push_start || st_q == core_map_pkg::ST_PUSH_HI;
  wire stk_rd = st_q == core_map_pkg::ST_POP_LO || st_q == core_map_pkg::ST_POP_HI;
  wire [15:0] sp_inc = sp_q + 16'h0001;
  wire [15:0] stk_addr = stk_rd ? sp_inc : sp_q;
  wire [8:0] stk_off = 9'(stk_addr - core_map_pkg::SRAM_BASE);
  // The high byte comes from a copy taken on the first push cycle, because
  // the counter already holds the call target when the second byte goes out
  wire [7:0] stk_byte = push_start ? ret_ext[7:0] : ret_hi_q;
  wire stk_act = stk_wr || (pop_start) || stk_rd;
  wire [8:0] ram_addr = stk_act ? stk_off : sram_off;
  wire ram_we = stk_wr || (d_wr && hit_sram && !stk_act);
  wire [7:0] ram_wd = stk_wr ? stk_byte : d_wdata;
  wire [7:0] ram_rd;
  logic sram_rd_q;
  logic [7:0] pop_lo_q;

  sram_512x8 #(.DEPTH(core_map_pkg::SRAM_BYTES), .AW(9)) u_sram (
    .clock(clock),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wd),
    .rdata(ram_rd)
  );

  // Pop address: first byte read issued in POP_LO, second in POP_HI;
  // the counter reloads in the idle cycle that follows POP_HI
  logic st_done_q;
  wire pop_done = st_q == core_map_pkg::ST_IDLE && st_done_q;

  // Program counter next value
  wire [PC_W-1:0] pc_seq = pc_q + PC_W'(long_insn ? 2 : 1);
  wire [PC_W-1:0] pc_rel = pc_q + PC_W'(rel_off) + PC_W'(1);
  // Fetch holds while the stack owns the memory port
  wire stall = st_q != core_map_pkg::ST_IDLE || push_start || pop_start;

  // Data read mux; SRAM data arrives one cycle later
  wire [7:0] sp_byte = hit_spl ? sp_q[7:0] : sp_q[15:8];
  wire [7:0] rd_now = hit_gpr ? gpr_q[gpr_idx] : (hit_spl || hit_sph) ? sp_byte : io_rdata;

  // Register file write: ALU result and data-space stores share one array
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < core_map_pkg::GPR_COUNT; i++) begin
        gpr_q[i] <= 8'h00;
      end
    end else if (d_wr && hit_gpr) begin
      gpr_q[gpr_idx] <= d_wdata;
    end else if (alu_we) begin
      gpr_q[rd_sel] <= alu_val;
    end
  end

  // Stack pointer: I/O writes, push decrement, pop increment
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sp_q <= core_map_pkg::SP_RESET;
    end else if (stk_wr) begin
      sp_q <= sp_q - 16'h0001;
    end else if (stk_rd) begin
      sp_q <= sp_inc;
    end else if (d_wr && hit_spl) begin
      sp_q <= {sp_q[15:8], d_wdata};
    end else if (d_wr && hit_sph) begin
      sp_q <= {d_wdata, sp_q[7:0]};
    end
  end

  // Stack FSM and captured return bytes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= core_map_pkg::ST_IDLE;
      st_done_q <= 1'b0;
      pop_lo_q <= 8'h00;
      ret_hi_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      // Busy registered from the next state so the output needs no decode
      busy_q <= st_d != core_map_pkg::ST_IDLE;
      st_done_q <= st_q == core_map_pkg::ST_POP_HI;
      if (st_q == core_map_pkg::ST_POP_HI) begin
        pop_lo_q <= ram_rd; // popped high byte read first
      end
      if (push_start) begin
        ret_hi_q <= ret_ext[15:8];
      end
    end
  end

  // Fetch/execute pipeline: fetch next word while executing current
  // Calls and interrupts share one target input; the caller supplies the vector
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= core_map_pkg::PC_RESET;
      insn_r <= 16'h0000;
    end else if (pop_done) begin
      pc_q <= PC_W'({pop_lo_q, ram_rd});
    end else if (push_start && call_req) begin
      pc_q <= call_target;
    end else if (push_start) begin
      pc_q <= call_target;
    end else if (!stall) begin
      insn_r <= pm_rdata;
      pc_q <= rel_jump ? pc_rel : pc_seq;
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      alu_r <= 8'h00;
      drd_r <= 8'h00;
      ptr_r <= 16'h0000;
      lpm_r <= 16'h0000;
      ioa_r <= 6'h00;
      iowd_r <= 8'h00;
      iowe_r <= 1'b0;
      iore_r <= 1'b0;
      sram_rd_q <= 1'b0;
    end else begin
      alu_r <= alu_val;
      ptr_r <= ptr_val;
      lpm_r <= z_val;
      ioa_r <= io_idx;
      iowd_r <= d_wdata;
      iowe_r <= d_wr && io_ext;
      iore_r <= d_rd && io_ext;
      sram_rd_q <= d_rd && hit_sram && !stk_act;
      // A read that went out to memory or a peripheral completes one cycle on
      if (iore_r) begin
        drd_r <= io_rdata;
      end else if (sram_rd_q) begin
        drd_r <= ram_rd;
      end
      if (d_rd && !hit_sram && !io_ext) begin
        drd_r <= rd_now;
      end
    end
  end

  assign alu_result = alu_r;
  // Read data from the holding register, so it stands until the next read
  assign d_rdata = drd_r;
  assign ptr_value = ptr_r;
  assign lpm_addr = lpm_r;
  assign pm_addr = pc_q;
  assign insn_q = insn_r;
  assign stack_pointer = sp_q;
  assign io_addr = ioa_r;
  assign io_wdata = iowd_r;
  assign io_we = iowe_r;
  assign io_re = iore_r;
  assign stack_busy = busy_q;
endmodule
`default_nettype wire

// ---- test/core_map_monitor.sv ----
// Port-level assertions for the register file and data map
`timescale 1ns/1ps
`default_nettype none
module core_map_monitor #(
  parameter int PC_W = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Requests
  input wire logic [7:0] imm,
  input wire logic use_imm,
  input wire logic [3:0] alu_op,
  input wire logic [15:0] d_addr,
  input wire logic d_wr,
  input wire logic [7:0] d_wdata,
  input wire logic io_direct,
  input wire logic rel_jump,
  input wire logic [11:0] rel_off,
  input wire logic call_req,
  input wire logic irq_req,
  input wire logic ret_req,
  input wire logic long_insn,
  // Results
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic [7:0] alu_result,
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic [15:0] stack_pointer,
  input wire logic stack_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Plain flow: no branch, no stack request, stack not busy now
  wire quiet = !rel_jump && !call_req && !irq_req && !ret_req && !stack_busy;
  sp_reset_a: assert property ($rose(rst_b) |-> stack_pointer == 16'h0000)
    else $error("stack pointer not cleared by reset");
  imm_mov_a: assert property (use_imm && alu_op == core_map_pkg::ALU_MOV && !stack_busy |=>
    alu_result == $past(imm)) else $error("immediate move result wrong");
  seq_fetch_a: assert property (quiet && !long_insn && !$past(stack_busy) |=>
    pm_addr == PC_W'($past(pm_addr) + 1)) else $error("fetch did not advance by one");
  long_fetch_a: assert property (quiet && long_insn && !$past(stack_busy) |=>
    pm_addr == PC_W'($past(pm_addr) + 2)) else $error("long word did not skip two");
  rel_jump_a: assert property (rel_jump && !stack_busy |=>
    pm_addr == PC_W'($past(pm_addr) + $past(rel_off) + 1)) else $error("relative jump target wrong");
  call_push_a: assert property (call_req && !stack_busy |=> stack_busy ##1
    stack_pointer == $past(stack_pointer, 2) - 16'h0002) else $error("push did not drop pointer by two");
  ret_pop_a: assert property (ret_req && !stack_busy |-> ##4
    stack_pointer == $past(stack_pointer, 4) + 16'h0002) else $error("pop did not raise pointer by two");
  io_write_a: assert property (d_wr && io_direct && !stack_busy && !(d_addr[5:0] inside {6'h3D, 6'h3E}) |=>
    io_we && io_addr == $past(d_addr[5:0]) && io_wdata == $past(d_wdata)) else $error("direct I/O write lost");
  sram_quiet_a: assert property (d_wr && !io_direct && d_addr >= 16'h0060 && !stack_busy |=>
    !io_we) else $error("memory store leaked to I/O");
  sp_io_a: assert property (d_wr && !io_direct && d_addr == 16'h005D && !stack_busy |=>
    stack_pointer[7:0] == $past(d_wdata)) else $error("pointer low byte not written");
endmodule
bind core_register_file_data_map core_map_monitor #(.PC_W(PC_W)) u_mon (.*);
`default_nettype wire

// ---- test/exec_side_model.sv ----
// Program memory and peripheral model on the far side of the core
`timescale 1ns/1ps
`default_nettype none
module exec_side_model (
  // Clock
  input wire logic clock,
  // Program fetch
  input wire logic [11:0] pm_addr,
  output logic [15:0] pm_rdata,
  // Peripheral space
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  output logic [7:0] io_rdata
);
  logic [7:0] io_mem [64];
  // Each word carries its own address, so fetch order shows
  assign pm_rdata = {4'hC, pm_addr};
  // Peripherals answer in the same cycle
  assign io_rdata = io_mem[io_addr];
  // Store peripheral writes
  always_ff @(posedge clock) begin
    if (io_we) begin
      io_mem[io_addr] <= io_wdata;
    end
  end
endmodule
`default_nettype wire

// ---- test/test_core_register_file_data_map.sv ----
// Self-checking bench for the register file and data map
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s: expected %h seen %h", n, e, g); end end
module test_core_register_file_data_map;
  logic clock = 1'h0, rst_b = 1'h0;
  logic [4:0] rd_sel = '0, rr_sel = '0;
  logic [7:0] imm = '0, d_wdata = '0, rv;
  logic use_imm = 1'h0, alu_we = 1'h0, d_rd = 1'h0, d_wr = 1'h0, io_direct = 1'h0;
  logic rel_jump = 1'h0, call_req = 1'h0, irq_req = 1'h0, ret_req = 1'h0, long_insn = 1'h0;
  logic [3:0] alu_op = '0;
  logic [15:0] d_addr = '0;
  logic [1:0] ptr_sel = '0;
  logic [11:0] rel_off = '0, call_target = '0, pm_addr, p, q;
  logic [15:0] pm_rdata, ptr_value, lpm_addr, insn_q, stack_pointer;
  logic [7:0] io_rdata, io_wdata, alu_result, d_rdata;
  logic [5:0] io_addr;
  logic io_we, io_re, stack_busy;
  int num_errors = 0, check_count = 0, cyc = 0;
  core_register_file_data_map u_dut (.*);
  exec_side_model u_far (.*);
  // Clock and hang guard; a run needs well under 1000 cycles
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Inputs move a fixed 2 ns after each rising edge
  task automatic step; @(posedge clock); #2; endtask
  task automatic mov(input logic [4:0] r, input logic [7:0] v);
    rd_sel = r; imm = v; use_imm = 1'h1; alu_op = core_map_pkg::ALU_MOV; alu_we = 1'h1;
    step; alu_we = 1'h0; use_imm = 1'h0; step;
  endtask
  task automatic dwr(input logic [15:0] a, input logic [7:0] v, input logic io);
    d_addr = a; d_wdata = v; io_direct = io; d_wr = 1'h1; step; d_wr = 1'h0; io_direct = 1'h0; step;
  endtask
  // Second step covers the one-cycle memory and peripheral read
  task automatic drd(input logic [15:0] a, input logic io);
    d_addr = a; io_direct = io; d_rd = 1'h1; step; d_rd = 1'h0; io_direct = 1'h0; step; rv = d_rdata;
  endtask
  task automatic alu(input logic [3:0] op, input logic [4:0] d, r, input logic ui, input logic [7:0] v);
    alu_op = op; rd_sel = d; rr_sel = r; use_imm = ui; imm = v; step; rv = alu_result;
  endtask
  task automatic wait_idle; repeat (8) if (stack_busy) step; `CHK("stack busy", 1'h0, stack_busy) endtask
  task automatic t_regs;
    for (int i = 0; i < 32; i++) mov(5'(i), 8'hA5 ^ 8'(i));
    for (int i = 0; i < 32; i++) begin
      drd(16'(i), 1'h0); `CHK("reg via data", 8'hA5 ^ 8'(i), rv)
    end
    dwr(16'h0003, 8'h3C, 1'h0); alu(core_map_pkg::ALU_MOV, 5'h00, 5'h03, 1'h0, 8'h00);
    `CHK("shared reg", 8'h3C, rv)
    mov(5'h01, 8'hF0); mov(5'h02, 8'h25); alu(core_map_pkg::ALU_ADD, 5'h01, 5'h02, 1'h0, 8'h00);
    `CHK("add", 8'h15, rv)
    alu(core_map_pkg::ALU_SUB, 5'h01, 5'h00, 1'h1, 8'h10); `CHK("sub imm", 8'hE0, rv)
    alu(core_map_pkg::ALU_INC, 5'h01, 5'h00, 1'h0, 8'h00); `CHK("inc", 8'hF1, rv)
    $display("registers test finished");
  endtask
  task automatic t_ptr;
    for (int k = 0; k < 3; k++) begin
      ptr_sel = 2'(k); step; step;
      `CHK("pointer", {8'hA5 ^ 8'(27 + 2 * k), 8'hA5 ^ 8'(26 + 2 * k)}, ptr_value)
    end
    `CHK("lookup", {8'hA5 ^ 8'h1F, 8'hA5 ^ 8'h1E}, lpm_addr)
    $display("pointer test finished");
  endtask
  task automatic t_mem;
    dwr(16'h0060, 8'h5A, 1'h0); dwr(16'h025F, 8'hC3, 1'h0);
    drd(16'h0060, 1'h0); `CHK("sram low", 8'h5A, rv)
    drd(16'h025F, 1'h0); `CHK("sram top", 8'hC3, rv)
    dwr(16'h0025, 8'h6E, 1'h0); drd(16'h0005, 1'h1); `CHK("io direct", 8'h6E, rv)
    dwr(16'h0007, 8'h11, 1'h1); drd(16'h0027, 1'h0); `CHK("io mapped", 8'h11, rv)
    d_addr = 16'h0005; io_direct = 1'h1; d_rd = 1'h1; step; d_rd = 1'h0; io_direct = 1'h0;
    `CHK("io read strobe", 1'h1, io_re)
    step; `CHK("io strobe end", 1'h0, io_re)
    $display("memory test finished");
  endtask
  task automatic t_stack;
    dwr(16'h005D, 8'h5F, 1'h0); dwr(16'h005E, 8'h02, 1'h0);
    `CHK("sp load", 16'h025F, stack_pointer)
    drd(16'h003E, 1'h1); `CHK("sp high", 8'h02, rv)
    p = pm_addr; call_target = 12'h123; call_req = 1'h1; step; call_req = 1'h0; wait_idle;
    `CHK("sp call", 16'h025D, stack_pointer)
    `CHK("call target", 12'h123, pm_addr)
    q = pm_addr; irq_req = 1'h1; step; irq_req = 1'h0; wait_idle;
    `CHK("sp irq", 16'h025B, stack_pointer)
    ret_req = 1'h1; step; ret_req = 1'h0; wait_idle; step;
    `CHK("sp ret", 16'h025D, stack_pointer)
    `CHK("inner return", q, pm_addr)
    ret_req = 1'h1; step; ret_req = 1'h0; wait_idle; step;
    `CHK("sp outer ret", 16'h025F, stack_pointer)
    `CHK("outer return", p, pm_addr)
    $display("stack test finished");
  endtask
  task automatic t_flow;
    step; p = pm_addr; step; `CHK("fetched word", {4'hC, p}, insn_q)
    long_insn = 1'h1; step; long_insn = 1'h0;
    p = pm_addr; rel_off = 12'hFFF; rel_jump = 1'h1; step; rel_jump = 1'h0;
    `CHK("wrap jump", p, pm_addr)
    $display("flow test finished");
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    #2 rst_b = 1'h1;
    `CHK("sp reset", 16'h0000, stack_pointer)
    t_regs;
    t_ptr;
    t_mem;
    t_stack;
    t_flow;
    stop_test;
  end
endmodule
`default_nettype wire
